// ==== optical_sample_fifo_status_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module optical_sample_fifo_status_bench
    import osf_pkg::*;
;
    localparam logic [18:0] LV1 = 19'h30201;
    localparam logic [18:0] LV2 = 19'h20403;
    localparam logic [18:0] LVA = 19'h01017;
    logic        core_clk    = 1'b0;
    logic        rst_n       = 1'b0;
    logic [7:0]  reg_addr    = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [7:0]  reg_wdata   = 8'h00;
    logic        sample_tick = 1'b0;
    logic [1:0]  pws         = 2'h3;
    logic [7:0]  rdata;
    logic        integ_start_q, e1, e2, pil, int_n_q, conv_done;
    logic [18:0] conv_value;
    logic [7:0]  b;
    int          num_errors  = 0;
    int          compares    = 0;

    always #10 core_clk = ~core_clk;

    osf_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .sample_tick(sample_tick),
        .pulse_width_select(pws), .conv_done(conv_done), .conv_value(conv_value),
        .integ_start_q(integ_start_q), .first_emitter_q(e1), .second_emitter_q(e2),
        .pilot_q(pil), .int_n_q(int_n_q));
    osf_front_model #(.LAT(4), .LVL_ONE(LV1), .LVL_TWO(LV2), .LVL_AMB(LVA)) fe (
        .core_clk(core_clk), .rst_n(rst_n), .integ_start_q(integ_start_q), .first_emitter_q(e1),
        .second_emitter_q(e2), .pilot_q(pil), .conv_done(conv_done), .conv_value(conv_value));

    function automatic logic [23:0] exp_word(input logic [18:0] v, input logic [1:0] pw);
        return {5'h00, v & (19'h7ffff << (2'h3 - pw))};
    endfunction : exp_word

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_pin(input logic exp);
        compares++;
        if (int_n_q !== exp) begin
            num_errors++;
            $display("Error int_n_q expected %b seen %b", exp, int_n_q);
        end
    endtask : chk_pin

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        d = rdata;
    endtask : reg_read

    task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
        reg_read(a, b);
        chk(what, {16'h0000, exp}, {16'h0000, b});
    endtask : chk_reg

    task automatic read_word(input logic [23:0] exp);
        logic [7:0] hi, md, lo;
        reg_read(OSF_A_DATA, hi);
        reg_read(OSF_A_DATA, md);
        reg_read(OSF_A_DATA, lo);
        chk("sample", exp, {hi, md, lo});
    endtask : read_word

    // polling host: available samples from lost count and both indices
    task automatic chk_avail(input logic [23:0] exp);
        logic [7:0]  lost;
        logic [7:0]  wr;
        logic [7:0]  rd;
        logic [23:0] n;
        reg_read(OSF_A_LOST, lost);
        reg_read(OSF_A_WR_IDX, wr);
        reg_read(OSF_A_RD_IDX, rd);
        if (lost != 8'h00) begin
            n = 24'h000020;
        end else if (wr > rd) begin
            n = {16'h0000, wr} - {16'h0000, rd};
        end else begin
            n = {16'h0000, wr} + 24'h000020 - {16'h0000, rd};
        end
        chk("available", exp, n);
    endtask : chk_avail

    // one tick per sample period; done once the sequencer has been quiet a while
    task automatic push(input int n);
        int q;
        repeat (n) begin
            @(posedge core_clk);
            #1 sample_tick = 1'b1;
            @(posedge core_clk);
            #1 sample_tick = 1'b0;
            q = 0;
            while (q < 30) begin
                @(posedge core_clk);
                q = (integ_start_q === 1'b1) ? 0 : q + 1;
            end
        end
    endtask : push

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        #1 rst_n = 1'b1;
        chk_reg("setup", OSF_A_SETUP, {1'b0, OSF_SETUP_RST});
        chk_reg("mask", OSF_A_MASK, OSF_MASK_RST);
        reg_write(8'h0b, 8'h5a);
        chk_reg("unmapped", 8'h0b, 8'h00);
        reg_write(OSF_A_WR_IDX, 8'h11);
        chk_reg("wr_idx", OSF_A_WR_IDX, 8'h00);
        chk_reg("empty", OSF_A_DATA, 8'h00);
        $display("test registers done");
        reg_write(OSF_A_SLOT_LO, 8'h21);
        reg_write(OSF_A_SLOT_HI, 8'h0c);
        push(1);
        chk_reg("wr_idx", OSF_A_WR_IDX, 8'h03);
        chk_reg("flags", OSF_A_FLAGS, 8'h40);
        chk_reg("flags", OSF_A_FLAGS, 8'h00);
        read_word(exp_word(LV1, 2'h3));
        read_word(exp_word(LV2, 2'h3));
        read_word(exp_word(LVA, 2'h3));
        $display("test sequential done");
        pws = 2'h0;
        reg_write(OSF_A_SLOT_LO, 8'h5d);
        push(1);
        read_word(exp_word(LV1 + LV2, 2'h0));
        read_word(exp_word(LV1, 2'h0));
        read_word(exp_word(LVA, 2'h0));
        pws = 2'h1;
        reg_write(OSF_A_SLOT_LO, 8'h01);
        reg_write(OSF_A_SLOT_HI, 8'h00);
        push(1);
        read_word(exp_word(LV1, 2'h1));
        pws = 2'h2;
        push(1);
        read_word(exp_word(LV1, 2'h2));
        pws = 2'h3;
        $display("test slots done");
        reg_write(OSF_A_MASK, 8'h80);
        reg_write(OSF_A_SETUP, 8'h0e);
        push(17);
        chk_pin(1'b1);
        push(1);
        chk_pin(1'b0);
        read_word(exp_word(LV1, 2'h3));
        chk_pin(1'b0);
        chk_reg("flags", OSF_A_FLAGS, 8'hc0);
        chk_pin(1'b1);
        push(1);
        chk_pin(1'b0);
        reg_write(OSF_A_SETUP, 8'h2e);
        reg_read(OSF_A_FLAGS, b);
        push(1);
        chk_pin(1'b1);
        reg_write(OSF_A_SETUP, 8'h4e);
        push(1);
        chk_pin(1'b0);
        read_word(exp_word(LV1, 2'h3));
        chk_pin(1'b1);
        $display("test watermark done");
        push(13);
        chk_reg("wr_idx", OSF_A_WR_IDX, 8'h0a);
        chk_reg("lost", OSF_A_LOST, 8'h00);
        chk_avail(24'h000020);
        reg_write(OSF_A_SETUP, 8'h0e);
        push(1);
        chk_reg("wr_idx", OSF_A_WR_IDX, 8'h0a);
        chk_reg("lost", OSF_A_LOST, 8'h01);
        chk_avail(24'h000020);
        reg_write(OSF_A_SETUP, 8'h1e);
        push(1);
        chk_reg("wr_idx", OSF_A_WR_IDX, 8'h0b);
        chk_reg("lost", OSF_A_LOST, 8'h02);
        read_word(exp_word(LV1, 2'h3));
        chk_reg("lost", OSF_A_LOST, 8'h00);
        reg_write(OSF_A_RD_IDX, 8'h1f);
        chk_reg("rd_idx", OSF_A_RD_IDX, 8'h1f);
        chk_avail(24'h00000c);
        read_word(exp_word(LV1, 2'h3));
        chk_reg("rd_idx", OSF_A_RD_IDX, 8'h00);
        $display("test full done");
        wrap_up();
    end
endmodule : optical_sample_fifo_status_bench
`default_nettype wire

// ==== osf_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module osf_front_model
    import osf_pkg::*;
#(
    parameter int          LAT     = 4,
    parameter logic [18:0] LVL_ONE = 19'h00001,
    parameter logic [18:0] LVL_TWO = 19'h00002,
    parameter logic [18:0] LVL_AMB = 19'h00003
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // sequencer side
    input  wire logic        integ_start_q,
    input  wire logic        first_emitter_q,
    input  wire logic        second_emitter_q,
    input  wire logic        pilot_q,
    // converter result
    output logic             conv_done,
    output logic      [18:0] conv_value
);
    int cnt_q;

    // the result only counts on conv_done; between results the value keeps toggling
    always_ff @(posedge core_clk) begin
        conv_done  <= 1'b0;
        conv_value <= ~conv_value;
        if (!rst_n) begin
            cnt_q      <= 0;
            conv_value <= 19'h00000;
        end else if (integ_start_q) begin
            cnt_q <= LAT;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
            if (cnt_q == 1) begin
                conv_done  <= 1'b1;
                // light seen is ambient plus whichever emitters are lit
                conv_value <= LVL_AMB + ((first_emitter_q | pilot_q) ? LVL_ONE : 19'h00000)
                              + (second_emitter_q ? LVL_TWO : 19'h00000);
            end
        end
    end
endmodule : osf_front_model
`default_nettype wire

// ==== osf_pkg.sv ====
package osf_pkg;
    localparam int          OSF_DEPTH       = 32;
    localparam int          OSF_PTR_W       = 5;
    localparam int          OSF_WORD_W      = 24;
    localparam int          OSF_ADC_W       = 19;
    localparam int          OSF_SLOTS       = 4;
    localparam logic [5:0]  OSF_FULL_COUNT  = 6'h20;
    localparam logic [4:0]  OSF_LOST_MAX    = 5'h1f;
    localparam logic [1:0]  OSF_LAST_BYTE   = 2'h2;
    localparam logic [1:0]  OSF_LAST_SLOT   = 2'h3;
    // register offsets
    localparam logic [7:0]  OSF_A_FLAGS     = 8'h00;
    localparam logic [7:0]  OSF_A_MASK      = 8'h02;
    localparam logic [7:0]  OSF_A_WR_IDX    = 8'h04;
    localparam logic [7:0]  OSF_A_LOST      = 8'h05;
    localparam logic [7:0]  OSF_A_RD_IDX    = 8'h06;
    localparam logic [7:0]  OSF_A_DATA      = 8'h07;
    localparam logic [7:0]  OSF_A_SETUP     = 8'h08;
    localparam logic [7:0]  OSF_A_SLOT_LO   = 8'h09;
    localparam logic [7:0]  OSF_A_SLOT_HI   = 8'h0a;
    // field positions and reset values
    localparam int          OSF_B_AFULL     = 7;
    localparam int          OSF_B_READY     = 6;
    localparam logic [6:0]  OSF_SETUP_RST   = 7'h0f;
    localparam logic [7:0]  OSF_MASK_RST    = 8'h00;
    localparam logic [7:0]  OSF_SLOT_RST    = 8'h00;
    // slot type codes
    localparam logic [3:0]  OSF_SLOT_NONE   = 4'h0;
    localparam logic [3:0]  OSF_SLOT_ONE    = 4'h1;
    localparam logic [3:0]  OSF_SLOT_TWO    = 4'h2;
    localparam logic [3:0]  OSF_SLOT_PILOT  = 4'h5;
    localparam logic [3:0]  OSF_SLOT_AMB    = 4'hc;
    localparam logic [3:0]  OSF_SLOT_BOTH   = 4'hd;

    typedef struct packed {
        logic       clear_on_data_read;
        logic       afull_type;
        logic       overwrite_when_full;
        logic [3:0] watermark;
    } osf_setup_t;

    typedef enum logic [1:0] {
        OSF_IDLE    = 2'b00,
        OSF_AMBIENT = 2'b01,
        OSF_EXPOSE  = 2'b11,
        OSF_PUSH    = 2'b10
    } osf_seq_t;
endpackage : osf_pkg

// ==== osf_sample_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
module osf_sample_ram #(
    parameter int W  = 24,
    parameter int D  = 32,
    parameter int AW = 5
) (
    // clock
    input  wire logic          core_clk,
    // write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // read side
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data_q
);
    logic [W-1:0] mem [D];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        rd_data_q <= mem[rd_addr];
    end
endmodule : osf_sample_ram
`default_nettype wire

// ==== osf_top.sv ====
// Functional notes
// - sample word holds converter msb at bit 18, upper bits zero.
// - pulse width select gives 19/18/17/16 bit resolution, low bits cleared.
// - almost full when stored count reaches 32 minus watermark.
// - almost full sets flag and drives interrupt low when mask bit set.
// - status read clears flag; data read also clears when clear-on-data-read set.
// - clear-on-data-read low leaves flags untouched by data reads.
// - full with overwrite set still pushes, discarding oldest sample.
// - full with overwrite clear drops sample, write index unchanged.
// - style low re-asserts almost full on every push while condition holds.
// - style high asserts almost full only when condition newly appears.
// - ambient phase leds off, exposure leds on, ambient subtracted.
// - direct ambient slot stores its own converted value in slot order with led results.
// - slots store results in successive locations each sample period.
// - sequence walks slots one to four, ending at first none or reserved slot.
// - lost count counts lost samples, saturates, clears on pop.
// - read index advances per sample, wraps, host writable.
// - each sample takes three data register reads.
`timescale 1ns/1ps
`default_nettype none
module osf_top
    import osf_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata_q,
    // conversion front end
    input  wire logic        sample_tick,
    input  wire logic [1:0]  pulse_width_select,
    input  wire logic        conv_done,
    input  wire logic [18:0] conv_value,
    output logic             integ_start_q,
    output logic             first_emitter_q,
    output logic             second_emitter_q,
    output logic             pilot_q,
    // interrupt pin
    output logic             int_n_q
);
    osf_setup_t       setup_q;
    logic [7:0]       mask_q;
    logic [7:0]       slot_lo_q;
    logic [7:0]       slot_hi_q;
    logic [7:6]       flags_q;
    logic [7:6]       flags_d;
    logic [4:0]       write_index_q;
    logic [4:0]       read_index_q;
    logic [4:0]       lost_sample_count_q;
    logic [5:0]       count_q;
    logic [1:0]       byte_q;
    logic             push_q;
    logic             cond_q;
    osf_seq_t         state_q;
    logic [1:0]       slot_q;
    logic [18:0]      amb_q;
    logic [23:0]      word_q;
    logic             seq_end_q;
    logic [23:0]      mem_q;

    function automatic logic [3:0] slot_code(input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] s);
        case (s)
            2'h0:    slot_code = lo[3:0];
            2'h1:    slot_code = lo[7:4];
            2'h2:    slot_code = hi[3:0];
            default: slot_code = hi[7:4];
        endcase
    endfunction : slot_code

    // reserved codes end the sequence like none, so no undefined slot is run
    function automatic logic active(input logic [3:0] c);
        active = (c == OSF_SLOT_ONE) || (c == OSF_SLOT_TWO) || (c == OSF_SLOT_PILOT) ||
                 (c == OSF_SLOT_AMB) || (c == OSF_SLOT_BOTH);
    endfunction : active

    function automatic osf_seq_t first_phase(input logic [3:0] c);
        first_phase = (c == OSF_SLOT_AMB) ? OSF_EXPOSE : OSF_AMBIENT;
    endfunction : first_phase

    // {pilot, second, first}
    function automatic logic [2:0] emitters(input logic [3:0] c);
        case (c)
            OSF_SLOT_ONE:   emitters = 3'h1;
            OSF_SLOT_TWO:   emitters = 3'h2;
            OSF_SLOT_PILOT: emitters = 3'h5;
            OSF_SLOT_BOTH:  emitters = 3'h3;
            default:        emitters = 3'h0;
        endcase
    endfunction : emitters

    function automatic logic [18:0] res_mask(input logic [1:0] pw);
        case (pw)
            2'h3:    res_mask = 19'h7ffff;
            2'h2:    res_mask = 19'h7fffe;
            2'h1:    res_mask = 19'h7fffc;
            default: res_mask = 19'h7fff8;
        endcase
    endfunction : res_mask

    // decode
    logic       status_rd;
    logic       data_rd;
    logic       idx_wr;
    logic       full;
    logic       push_req;
    logic       write;
    logic       pop;
    logic       ovr;
    logic       cond;
    logic       afull_set;
    logic       flag_clr;
    logic [3:0] cur_code;
    logic [3:0] next_code;
    logic [4:0] wr_next;
    logic [4:0] rd_new;
    logic [18:0] corrected;
    logic [7:0]  mask_d;

    assign status_rd = reg_rd && (reg_addr == OSF_A_FLAGS);
    assign data_rd   = reg_rd && (reg_addr == OSF_A_DATA);
    assign idx_wr    = reg_wr && (reg_addr == OSF_A_RD_IDX);
    assign full      = (count_q == OSF_FULL_COUNT);
    assign push_req  = (state_q == OSF_PUSH);
    assign pop       = data_rd && (count_q != 6'h00) && (byte_q == OSF_LAST_BYTE);
    assign write     = push_req && (!full || pop || setup_q.overwrite_when_full);
    assign ovr       = write && full && !pop;
    assign wr_next   = write_index_q + {4'h0, write};
    assign rd_new    = reg_wdata[4:0];
    assign cond      = count_q >= (OSF_FULL_COUNT - {2'h0, setup_q.watermark});
    assign afull_set = setup_q.afull_type ? (cond && !cond_q) : (push_q && cond);
    assign flag_clr  = status_rd || (data_rd && setup_q.clear_on_data_read);
    assign cur_code  = slot_code(slot_lo_q, slot_hi_q, slot_q);
    assign next_code = slot_code(slot_lo_q, slot_hi_q, slot_q + 2'h1);
    assign corrected = (conv_value > amb_q) ? (conv_value - amb_q) : 19'h00000;
    // the pin must follow a mask write at the same edge as the mask itself
    assign mask_d    = (reg_wr && reg_addr == OSF_A_MASK) ? {reg_wdata[7:3], 3'h0} : mask_q;

    // set wins over clear
    always_comb begin
        flags_d[OSF_B_AFULL] = afull_set || (flags_q[OSF_B_AFULL] && !flag_clr);
        flags_d[OSF_B_READY] = seq_end_q || (flags_q[OSF_B_READY] && !flag_clr);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flags_q <= 2'h0;
            int_n_q <= 1'b1;
            cond_q  <= 1'b0;
            push_q  <= 1'b0;
        end else begin
            flags_q <= flags_d;
            int_n_q <= !((flags_d[OSF_B_AFULL] && mask_d[OSF_B_AFULL]) ||
                         (flags_d[OSF_B_READY] && mask_d[OSF_B_READY]));
            cond_q  <= cond;
            push_q  <= write;
        end
    end

    // configuration registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            setup_q   <= OSF_SETUP_RST;
            mask_q    <= OSF_MASK_RST;
            slot_lo_q <= OSF_SLOT_RST;
            slot_hi_q <= OSF_SLOT_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                OSF_A_MASK:    mask_q    <= {reg_wdata[7:3], 3'h0};
                OSF_A_SETUP:   setup_q   <= reg_wdata[6:0];
                OSF_A_SLOT_LO: slot_lo_q <= reg_wdata;
                OSF_A_SLOT_HI: slot_hi_q <= reg_wdata;
                default:       ;
            endcase
        end
    end

    // queue indices; a host index write in the same cycle as a pop takes precedence
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            write_index_q       <= 5'h00;
            read_index_q        <= 5'h00;
            lost_sample_count_q <= 5'h00;
            count_q             <= 6'h00;
            byte_q              <= 2'h0;
        end else begin
            write_index_q <= wr_next;
            if (idx_wr) begin
                read_index_q <= rd_new;
                count_q      <= {1'b0, wr_next - rd_new};
                byte_q       <= 2'h0;
            end else begin
                read_index_q <= read_index_q + {4'h0, pop || ovr};
                count_q      <= count_q + {5'h00, write && !ovr} - {5'h00, pop};
                if (data_rd && count_q != 6'h00) begin
                    byte_q <= (byte_q == OSF_LAST_BYTE) ? 2'h0 : byte_q + 2'h1;
                end
            end
            if (pop) begin
                lost_sample_count_q <= 5'h00;
            end else if (push_req && full && lost_sample_count_q != OSF_LOST_MAX) begin
                lost_sample_count_q <= lost_sample_count_q + 5'h01;
            end
        end
    end

    // overwrite during a partly read sample can mix bytes of two samples
    osf_sample_ram #(
        .W  (OSF_WORD_W),
        .D  (OSF_DEPTH),
        .AW (OSF_PTR_W)
    ) u_ram (
        .core_clk  (core_clk),
        .wr_en     (write),
        .wr_addr   (write_index_q),
        .wr_data   (word_q),
        .rd_addr   (read_index_q),
        .rd_data_q (mem_q)
    );

    // register read data
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OSF_A_FLAGS:   reg_rdata_q <= {flags_q, 6'h00};
                OSF_A_MASK:    reg_rdata_q <= mask_q;
                OSF_A_WR_IDX:  reg_rdata_q <= {3'h0, write_index_q};
                OSF_A_LOST:    reg_rdata_q <= {3'h0, lost_sample_count_q};
                OSF_A_RD_IDX:  reg_rdata_q <= {3'h0, read_index_q};
                OSF_A_DATA: begin
                    if (count_q == 6'h00) begin
                        reg_rdata_q <= 8'h00;
                    end else begin
                        case (byte_q)
                            2'h0:    reg_rdata_q <= mem_q[23:16];
                            2'h1:    reg_rdata_q <= mem_q[15:8];
                            default: reg_rdata_q <= mem_q[7:0];
                        endcase
                    end
                end
                OSF_A_SETUP:   reg_rdata_q <= {1'b0, setup_q};
                OSF_A_SLOT_LO: reg_rdata_q <= slot_lo_q;
                OSF_A_SLOT_HI: reg_rdata_q <= slot_hi_q;
                default:       reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // exposure sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q          <= OSF_IDLE;
            slot_q           <= 2'h0;
            amb_q            <= 19'h00000;
            word_q           <= 24'h000000;
            seq_end_q        <= 1'b0;
            integ_start_q    <= 1'b0;
            first_emitter_q  <= 1'b0;
            second_emitter_q <= 1'b0;
            pilot_q          <= 1'b0;
        end else begin
            integ_start_q <= 1'b0;
            seq_end_q     <= 1'b0;
            case (state_q)
                OSF_IDLE: begin
                    slot_q <= 2'h0;
                    amb_q  <= 19'h00000;
                    if (sample_tick && active(slot_lo_q[3:0])) begin
                        state_q       <= first_phase(slot_lo_q[3:0]);
                        integ_start_q <= 1'b1;
                        {pilot_q, second_emitter_q, first_emitter_q} <= 3'h0;
                    end
                end
                OSF_AMBIENT: begin
                    if (conv_done) begin
                        amb_q         <= conv_value;
                        state_q       <= OSF_EXPOSE;
                        integ_start_q <= 1'b1;
                        {pilot_q, second_emitter_q, first_emitter_q} <= emitters(cur_code);
                    end
                end
                OSF_EXPOSE: begin
                    if (conv_done) begin
                        word_q  <= {5'h00, corrected & res_mask(pulse_width_select)};
                        state_q <= OSF_PUSH;
                        {pilot_q, second_emitter_q, first_emitter_q} <= 3'h0;
                    end
                end
                OSF_PUSH: begin
                    amb_q <= 19'h00000;
                    if (slot_q == OSF_LAST_SLOT || !active(next_code)) begin
                        state_q   <= OSF_IDLE;
                        seq_end_q <= 1'b1;
                    end else begin
                        slot_q        <= slot_q + 2'h1;
                        state_q       <= first_phase(next_code);
                        integ_start_q <= 1'b1;
                    end
                end
                default: state_q <= OSF_IDLE;
            endcase
        end
    end

    chk_word_msb_place: assert property (@(posedge core_clk) disable iff (!rst_n)
        push_req |-> (word_q[23:19] == 5'h00)) else $error("upper sample bits not zero");
    chk_res_low_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == OSF_EXPOSE && conv_done && pulse_width_select == 2'h0) |=> (word_q[2:0] == 3'h0))
        else $error("low bits kept at 16 bit resolution");
    chk_afull_reassert: assert property (@(posedge core_clk) disable iff (!rst_n)
        (write && !setup_q.afull_type && count_q + 6'h01 >= OSF_FULL_COUNT - {2'h0, setup_q.watermark}
         && !ovr && !pop && !idx_wr) |=> ##1 flags_q[OSF_B_AFULL]) else $error("almost full not raised after push");
    chk_int_pin_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flags_q[OSF_B_AFULL] && mask_q[OSF_B_AFULL]) |-> !int_n_q) else $error("interrupt pin not low");
    chk_status_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (status_rd && !afull_set) |=> !flags_q[OSF_B_AFULL]) else $error("status read did not clear");
    chk_data_keeps_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        (data_rd && !setup_q.clear_on_data_read && flags_q[OSF_B_AFULL]) |=> flags_q[OSF_B_AFULL])
        else $error("data read cleared flag");
    chk_drop_when_full: assert property (@(posedge core_clk) disable iff (!rst_n)
        (push_req && full && !setup_q.overwrite_when_full && !pop) |=> $stable(write_index_q))
        else $error("write index moved on drop");
    chk_overwrite_full: assert property (@(posedge core_clk) disable iff (!rst_n)
        (push_req && full && setup_q.overwrite_when_full && !pop && !idx_wr) |=>
        (write_index_q == $past(write_index_q) + 5'h01) && full) else $error("overwrite push missing");
    chk_lost_cleared: assert property (@(posedge core_clk) disable iff (!rst_n)
        pop |=> (lost_sample_count_q == 5'h00)) else $error("lost count not cleared");
    chk_ambient_dark: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == OSF_AMBIENT) |-> !(first_emitter_q || second_emitter_q || pilot_q))
        else $error("emitter lit in ambient phase");
endmodule : osf_top
`default_nettype wire
